// File: hw/imc_pkg.sv
package imc_pkg;

   // ----------------------------------------------------------------
   // widths and sources
   // ----------------------------------------------------------------
   localparam int IMC_DW   = 8;
   localparam int IMC_NSRC = 5;

   // ----------------------------------------------------------------
   // first control byte: global enable, per-source enables, flags
   // ----------------------------------------------------------------
   localparam int IMC_F_GIE  = 0;
   localparam int IMC_F_EXTE = 1;
   localparam int IMC_F_T0E  = 2;
   localparam int IMC_F_T1E  = 3;
   localparam int IMC_F_EXTF = 4;
   localparam int IMC_F_T0F  = 5;
   localparam int IMC_F_T1F  = 6;
   localparam logic [IMC_DW-1:0] IMC_FIRST_MASK  = 8'h7f;  // bit 7 unimplemented
   localparam logic [IMC_DW-1:0] IMC_FIRST_RESET = 8'h00;

   // ----------------------------------------------------------------
   // second control byte: time base and converter
   // ----------------------------------------------------------------
   localparam int IMC_S_TBE  = 0;
   localparam int IMC_S_ADE  = 1;
   localparam int IMC_S_TBF  = 4;
   localparam int IMC_S_ADF  = 5;
   localparam logic [IMC_DW-1:0] IMC_SECOND_MASK  = 8'h33;
   localparam logic [IMC_DW-1:0] IMC_SECOND_RESET = 8'h00;

   // ----------------------------------------------------------------
   // vector addresses
   // ----------------------------------------------------------------
   localparam logic [IMC_DW-1:0] IMC_VEC_EXT  = 8'h04;
   localparam logic [IMC_DW-1:0] IMC_VEC_T0   = 8'h08;
   localparam logic [IMC_DW-1:0] IMC_VEC_T1   = 8'h0c;
   localparam logic [IMC_DW-1:0] IMC_VEC_TB   = 8'h10;
   localparam logic [IMC_DW-1:0] IMC_VEC_ADC  = 8'h14;
   localparam logic [IMC_DW-1:0] IMC_VEC_NONE = 8'h00;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // one bit per source, highest priority in the top bit
   typedef struct packed {
      logic ext;
      logic t0;
      logic t1;
      logic tb;
      logic adc;
   } imc_src_t;

   typedef struct packed {
      logic              we_first;
      logic              we_second;
      logic [IMC_DW-1:0] wdata;
   } imc_wr_t;

   typedef struct packed {
      logic              valid;
      logic [IMC_DW-1:0] addr;
   } imc_call_t;

endpackage

// File: hw/imc_irq_logic.sv
`timescale 1ns/1ps
// Overview of operation
// - timer interrupt taken only with global enable and that timer's enable set
// - timer 0 or 1 overflow sets that timer's request flag
// - accepted timer 0 calls vector 08h, timer 1 calls vector 0ch
// - servicing clears the source flag and the global enable
// - time base interrupt needs global enable and time base enable
// - time base overflow sets the time base request flag
// - accepted time base interrupt calls vector 10h
// - converter interrupt needs global enable and converter enable
// - end of conversion sets the converter request flag
// - accepted converter interrupt calls vector 14h
// - no vectoring while the stack is full; requests wait
// - set flags stay set until serviced or cleared by software
// - every source can wake the core from power-down
// - entry saves only the program counter, nothing else
// - simultaneous requests go external, timer 0, timer 1, time base, converter
// - requests are still recorded while the global enable is clear
// - requests between two phase-two rises are serviced at the later rise
module imc_irq_logic
(
   // clock and reset
   input  wire  logic                      clk,
   input  wire  logic                      rst,
   // source events, one-cycle pulses
   input  wire  imc_pkg::imc_src_t         src_event,
   // core timing and state
   input  wire  logic                      machine_phase_two,
   input  wire  logic                      stack_full,
   input  wire  logic                      powered_down,
   // software writes to the two control bytes
   input  wire  imc_pkg::imc_wr_t          sw_wr,
   // control bytes as read back by software
   output logic [imc_pkg::IMC_DW-1:0]      irq_control_first,
   output logic [imc_pkg::IMC_DW-1:0]      irq_control_second,
   // vector call and wake request to the core
   output imc_pkg::imc_call_t              vector_call,
   output logic                            wake_req
);
   import imc_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // flags gathered from both control bytes
   function automatic imc_src_t flags_of(input logic [IMC_DW-1:0] f, input logic [IMC_DW-1:0] s);
      imc_src_t r;
      r.ext = f[IMC_F_EXTF];
      r.t0  = f[IMC_F_T0F];
      r.t1  = f[IMC_F_T1F];
      r.tb  = s[IMC_S_TBF];
      r.adc = s[IMC_S_ADF];
      return r;
   endfunction

   // per-source enables gathered from both control bytes
   function automatic imc_src_t enables_of(input logic [IMC_DW-1:0] f, input logic [IMC_DW-1:0] s);
      imc_src_t r;
      r.ext = f[IMC_F_EXTE];
      r.t0  = f[IMC_F_T0E];
      r.t1  = f[IMC_F_T1E];
      r.tb  = s[IMC_S_TBE];
      r.adc = s[IMC_S_ADE];
      return r;
   endfunction

   // fixed priority pick, one-hot result
   function automatic imc_src_t first_set(input imc_src_t p);
      imc_src_t r;
      r     = '0;
      if (p.ext) begin
         r.ext = 1'b1;
      end else if (p.t0) begin
         r.t0 = 1'b1;
      end else if (p.t1) begin
         r.t1 = 1'b1;
      end else if (p.tb) begin
         r.tb = 1'b1;
      end else if (p.adc) begin
         r.adc = 1'b1;
      end
      return r;
   endfunction

   // vector of a one-hot selection
   function automatic logic [IMC_DW-1:0] vec_of(input imc_src_t s);
      logic [IMC_DW-1:0] v;
      v = IMC_VEC_NONE;
      if (s.ext) begin
         v = IMC_VEC_EXT;
      end else if (s.t0) begin
         v = IMC_VEC_T0;
      end else if (s.t1) begin
         v = IMC_VEC_T1;
      end else if (s.tb) begin
         v = IMC_VEC_TB;
      end else if (s.adc) begin
         v = IMC_VEC_ADC;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [IMC_DW-1:0] first_r;
   logic [IMC_DW-1:0] first_nxt;
   logic [IMC_DW-1:0] second_r;
   logic [IMC_DW-1:0] second_nxt;
   logic              phase_prev_r;
   imc_call_t         call_r;
   imc_call_t         call_nxt;
   logic              wake_r;
   logic              wake_nxt;

   imc_src_t          flags;
   imc_src_t          enables;
   imc_src_t          pending;
   imc_src_t          sel;
   imc_src_t          flags_nxt;
   logic              phase_rise;
   logic              take;

   // ----------------------------------------------------------------
   // acceptance decision
   // ----------------------------------------------------------------
   // service is only decided on a phase-two rise, so anything that
   // came in since the previous rise is weighed together
   always_comb begin
      flags      = flags_of(first_r, second_r);
      enables    = enables_of(first_r, second_r);
      pending    = flags & enables;
      sel        = first_set(pending);
      phase_rise = machine_phase_two & ~phase_prev_r;
      take       = phase_rise & first_r[IMC_F_GIE] & (|pending) & ~stack_full;
   end

   // ----------------------------------------------------------------
   // control bytes
   // ----------------------------------------------------------------
   // order: service clears, then software write, then hardware sets,
   // so an event in the cycle of its clear is never lost
   always_comb begin
      first_nxt  = first_r;
      second_nxt = second_r;
      if (take) begin
         first_nxt[IMC_F_GIE] = 1'b0;
      end
      if (sw_wr.we_first) begin
         first_nxt = sw_wr.wdata & IMC_FIRST_MASK;
      end
      if (sw_wr.we_second) begin
         second_nxt = sw_wr.wdata & IMC_SECOND_MASK;
      end
      flags_nxt = flags_of(first_nxt, second_nxt);
      if (take && !sw_wr.we_first && !sw_wr.we_second) begin
         flags_nxt = flags_nxt & ~sel;
      end else if (take) begin
         // a write in the same cycle already decided the flag bits it covers
         flags_nxt.ext = flags_nxt.ext & ~(sel.ext & ~sw_wr.we_first);
         flags_nxt.t0  = flags_nxt.t0 & ~(sel.t0 & ~sw_wr.we_first);
         flags_nxt.t1  = flags_nxt.t1 & ~(sel.t1 & ~sw_wr.we_first);
         flags_nxt.tb  = flags_nxt.tb & ~(sel.tb & ~sw_wr.we_second);
         flags_nxt.adc = flags_nxt.adc & ~(sel.adc & ~sw_wr.we_second);
      end
      // sets are independent of any enable, so they also record while blocked
      flags_nxt                = flags_nxt | src_event;
      first_nxt[IMC_F_EXTF]    = flags_nxt.ext;
      first_nxt[IMC_F_T0F]     = flags_nxt.t0;
      first_nxt[IMC_F_T1F]     = flags_nxt.t1;
      second_nxt[IMC_S_TBF]    = flags_nxt.tb;
      second_nxt[IMC_S_ADF]    = flags_nxt.adc;
   end

   // ----------------------------------------------------------------
   // call and wake outputs
   // ----------------------------------------------------------------
   // the core only pushes its program counter; no other state is saved
   always_comb begin
      call_nxt.valid = take;
      call_nxt.addr  = take ? vec_of(sel) : IMC_VEC_NONE;
      wake_nxt       = powered_down & (|pending);
   end

   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         first_r      <= IMC_FIRST_RESET;
         second_r     <= IMC_SECOND_RESET;
         phase_prev_r <= 1'b0;
         call_r       <= '0;
         wake_r       <= 1'b0;
      end else begin
         first_r      <= first_nxt;
         second_r     <= second_nxt;
         phase_prev_r <= machine_phase_two;
         call_r       <= call_nxt;
         wake_r       <= wake_nxt;
      end
   end

   assign irq_control_first  = first_r;
   assign irq_control_second = second_r;
   assign vector_call        = call_r;
   assign wake_req           = wake_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence seq_accept;
      phase_rise && first_r[IMC_F_GIE] && !stack_full && (|pending);
   endsequence

   sequence seq_call(logic [IMC_DW-1:0] v);
      vector_call.valid && (vector_call.addr == v);
   endsequence

   property p_vectors(logic pick, logic [IMC_DW-1:0] v);
      seq_accept ##0 pick |=> seq_call(v);
   endproperty

   chk_call_needs_gie: assert property (vector_call.valid |-> $past(first_r[IMC_F_GIE]))
      else $error("vector call without global enable");

   chk_t0_flag_set: assert property (src_event.t0 |=> first_r[IMC_F_T0F])
      else $error("timer 0 event did not set its flag");

   chk_t1_flag_set: assert property (src_event.t1 |=> first_r[IMC_F_T1F])
      else $error("timer 1 event did not set its flag");

   chk_t0_vector: assert property (p_vectors(sel.t0, IMC_VEC_T0))
      else $error("timer 0 vector wrong");

   chk_t1_vector: assert property (p_vectors(sel.t1, IMC_VEC_T1))
      else $error("timer 1 vector wrong");

   chk_gie_cleared: assert property (seq_accept ##0 !sw_wr.we_first |=> !first_r[IMC_F_GIE])
      else $error("global enable not cleared on service");

   chk_flag_cleared: assert property
      (seq_accept ##0 sel.t0 && !src_event.t0 && !sw_wr.we_first |=> !first_r[IMC_F_T0F])
      else $error("serviced flag not cleared");

   chk_tb_needs_en: assert property
      (seq_call(IMC_VEC_TB) |-> $past(second_r[IMC_S_TBE] && second_r[IMC_S_TBF]))
      else $error("time base call without its enable");

   chk_tb_flag_set: assert property (src_event.tb |=> second_r[IMC_S_TBF])
      else $error("time base event did not set its flag");

   chk_tb_vector: assert property (p_vectors(sel.tb, IMC_VEC_TB))
      else $error("time base vector wrong");

   chk_adc_needs_en: assert property
      (seq_call(IMC_VEC_ADC) |-> $past(second_r[IMC_S_ADE] && first_r[IMC_F_GIE]))
      else $error("converter call without its enable");

   chk_adc_flag_set: assert property (src_event.adc |=> second_r[IMC_S_ADF])
      else $error("conversion end did not set its flag");

   chk_adc_vector: assert property (p_vectors(sel.adc, IMC_VEC_ADC))
      else $error("converter vector wrong");

   chk_stack_full: assert property (stack_full |=> !vector_call.valid)
      else $error("vectored while stack full");

   chk_flag_holds: assert property
      (first_r[IMC_F_T0F] && !take && !sw_wr.we_first |=> first_r[IMC_F_T0F])
      else $error("timer 0 flag dropped on its own");

   chk_wake_any: assert property (powered_down && (|pending) |=> wake_req)
      else $error("pending source did not wake core");

   chk_call_pulse: assert property (vector_call.valid |=> !vector_call.valid)
      else $error("vector call longer than one cycle");

   chk_priority: assert property
      (seq_accept ##0 pending.ext && pending.t0 |=> seq_call(IMC_VEC_EXT))
      else $error("priority order violated");

   chk_record_blocked: assert property
      (!first_r[IMC_F_GIE] && src_event.adc |=> second_r[IMC_S_ADF])
      else $error("request lost while blocked");

   chk_phase_edge: assert property
      (vector_call.valid |-> $past(machine_phase_two) && !$past(phase_prev_r))
      else $error("call not on a phase-two rise");

   chk_sw_write: assert property
      (sw_wr.we_second && !(|src_event) |=> second_r == ($past(sw_wr.wdata) & IMC_SECOND_MASK))
      else $error("software write not stored");

   chk_ext_vector: assert property (p_vectors(sel.ext, IMC_VEC_EXT))
      else $error("external vector wrong");

   chk_idle_addr: assert property (!vector_call.valid |-> vector_call.addr == IMC_VEC_NONE)
      else $error("vector address shown without a call");

endmodule

// File: bench/imc_core_model.sv
`timescale 1ns/1ps
module imc_core_model
   import imc_pkg::*;
#(
   parameter int DEPTH = 2
)(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // calls from the interrupt logic, return and halt from the bench
   input  wire imc_pkg::imc_call_t vector_call,
   input  wire logic               wake_req,
   input  wire logic               ret_pulse,
   input  wire logic               halt_req,
   // core state seen by the interrupt logic; stack depth for the bench
   output logic                    machine_phase_two,
   output logic                    stack_full,
   output logic                    powered_down,
   output logic [3:0]              depth_r
);
   logic [1:0] phase_r, phase_nxt;
   logic [3:0] depth_nxt;
   logic       pd_r, pd_nxt;

   // ----------------------------------------------------------------
   // stack depth, phase counter, power-down state
   // ----------------------------------------------------------------
   // a call pushes the program counter and nothing else, so depth is all we keep
   always_comb begin
      phase_nxt = phase_r + 2'h1;
      depth_nxt = depth_r;
      if (vector_call.valid) begin
         depth_nxt = depth_nxt + 4'h1;
      end
      if (ret_pulse && depth_r != 4'h0) begin
         depth_nxt = depth_nxt - 4'h1;
      end
      pd_nxt = (pd_r | halt_req) & ~wake_req;
   end

   // state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= 2'h0;
         depth_r <= 4'h0;
         pd_r    <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         depth_r <= depth_nxt;
         pd_r    <= pd_nxt;
      end
   end

   // one phase-two rise every four cycles
   assign machine_phase_two = (phase_r == 2'h3);
   assign stack_full        = (depth_r == 4'(DEPTH));
   assign powered_down      = pd_r;
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import imc_pkg::*;
   logic       clk, rst, ret_pulse, halt_req, phase2, stack_full, powered_down, wake_req, seen;
   imc_src_t   src_event;
   imc_wr_t    sw_wr;
   imc_call_t  vector_call;
   logic [7:0] first, second;
   logic [3:0] depth;
   logic [8:0] call;
   logic [15:0] lfsr;
   logic [4:0] en, fl;
   int         failures, tests_run, got;

   imc_irq_logic uut (.clk(clk), .rst(rst), .src_event(src_event), .machine_phase_two(phase2),
      .stack_full(stack_full), .powered_down(powered_down), .sw_wr(sw_wr), .irq_control_first(first),
      .irq_control_second(second), .vector_call(vector_call), .wake_req(wake_req));
   imc_core_model #(.DEPTH(2)) core (.clk(clk), .rst(rst), .vector_call(vector_call), .wake_req(wake_req),
      .ret_pulse(ret_pulse), .halt_req(halt_req), .machine_phase_two(phase2), .stack_full(stack_full),
      .powered_down(powered_down), .depth_r(depth));

   // ----------------------------------------------------------------
   // expectation helpers, sources indexed in priority order
   // ----------------------------------------------------------------
   function automatic logic [7:0] first_b(logic g, logic [4:0] e, logic [4:0] f);
      return {1'b0, f[2], f[1], f[0], e[2], e[1], e[0], g};
   endfunction
   function automatic logic [7:0] second_b(logic [4:0] e, logic [4:0] f);
      return {2'b00, f[4], f[3], 2'b00, e[4], e[3]};
   endfunction
   function automatic int pick(logic [4:0] p);
      for (int i = 0; i < 5; i++) begin
         if (p[i]) return i;
      end
      return 5;
   endfunction
   function automatic logic [7:0] vec(int i);
      return 8'(4 * (i + 1));
   endfunction
   function automatic logic [15:0] step(logic [15:0] l);
      return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
   endfunction

   // ----------------------------------------------------------------
   // drivers and comparison
   // ----------------------------------------------------------------
   task automatic check(logic [8:0] g, logic [8:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(logic [1:0] we, logic [7:0] d);
      @(negedge clk) sw_wr = {we, d};
      @(negedge clk) sw_wr = '0;
   endtask
   // first byte goes first so the global enable drops before the second changes
   task automatic set_all(logic g, logic [4:0] e, logic [4:0] f);
      wr(2'b10, first_b(g, e, f));
      wr(2'b01, second_b(e, f));
   endtask
   task automatic regs(logic g, logic [4:0] e, logic [4:0] f);
      check({1'b0, first}, {1'b0, first_b(g, e, f)});
      check({1'b0, second}, {1'b0, second_b(e, f)});
   endtask
   task automatic fire(logic [4:0] p);
      @(negedge clk) src_event = imc_src_t'({p[0], p[1], p[2], p[3], p[4]});
      @(negedge clk) src_event = '0;
   endtask
   task automatic pulse_ret();
      @(negedge clk) ret_pulse = 1'b1;
      @(negedge clk) ret_pulse = 1'b0;
   endtask
   // keeps the first call seen; a window of six covers one phase period plus latency
   task automatic wait_call(int n);
      call = '0;
      repeat (n) begin
         @(negedge clk);
         if (vector_call.valid === 1'b1 && call[8] !== 1'b1) call = vector_call;
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // watchdog, far beyond the fewer than a thousand cycles the sequence needs
   initial begin
      #(25 * 20000);
      failures++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1; ret_pulse = 1'b0; halt_req = 1'b0; src_event = '0; sw_wr = '0;
      failures = 0; tests_run = 0; lfsr = 16'h0008;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      regs(1'b0, 5'h00, 5'h00);
      check(vector_call, 9'h000);
      // all five pending at once, served one per enable in priority order
      set_all(1'b0, 5'h1f, 5'h00);
      fire(5'h1f);
      regs(1'b0, 5'h1f, 5'h1f);
      fl = 5'h1f;
      for (int i = 0; i < 5; i++) begin
         wr(2'b10, first_b(1'b1, 5'h1f, fl));
         wait_call(6);
         check(call, {1'b1, vec(i)});
         fl[i] = 1'b0;
         regs(1'b0, 5'h1f, fl);
         pulse_ret();
      end
      // two calls fill the stack, the third must wait for a return
      for (int k = 0; k < 3; k++) begin
         fire(5'h02);
         wr(2'b10, first_b(1'b1, 5'h1f, 5'h02));
         wait_call(k == 2 ? 12 : 6);
         check(call, k == 2 ? 9'h000 : {1'b1, 8'h08});
      end
      regs(1'b1, 5'h1f, 5'h02);
      check({5'h00, depth}, 9'h002);
      pulse_ret();
      wait_call(6);
      check(call, {1'b1, 8'h08});
      pulse_ret();
      pulse_ret();
      // random enables against random events, gating and priority
      repeat (30) begin
         lfsr = step(lfsr);
         en = lfsr[4:0];
         fl = lfsr[9:5];
         set_all(1'b0, en, 5'h00);
         fire(fl);
         wr(2'b10, first_b(1'b1, en, fl));
         wait_call(6);
         got = pick(en & fl);
         check(call, got == 5 ? 9'h000 : {1'b1, vec(got)});
         if (got < 5) fl[got] = 1'b0;
         regs(got == 5, en, fl);
         set_all(1'b0, 5'h00, 5'h00);
         regs(1'b0, 5'h00, 5'h00);
         if (got < 5) pulse_ret();
      end
      // each source alone wakes the core, global enable off
      for (int i = 0; i < 5; i++) begin
         set_all(1'b0, 5'(1 << i), 5'h00);
         @(negedge clk) halt_req = 1'b1;
         @(negedge clk) halt_req = 1'b0;
         @(negedge clk);
         check({8'h00, wake_req}, 9'h000);
         fire(5'(1 << i));
         seen = 1'b0;
         repeat (4) begin
            @(negedge clk);
            if (wake_req === 1'b1) seen = 1'b1;
         end
         check({8'h00, seen}, 9'h001);
         check(vector_call, 9'h000);
         set_all(1'b0, 5'h00, 5'h00);
      end
      end_of_test();
   end
endmodule
